// file: src/fnd_pkg.sv
package fnd_pkg;
  // clock rate and calibration times
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned CAL_LONG_US   = 115;
  localparam int unsigned CAL_SHORT_US  = 5;
  localparam int unsigned CAL_LONG_CYC  = CAL_LONG_US * CLK_MHZ;
  localparam int unsigned CAL_SHORT_CYC = CAL_SHORT_US * CLK_MHZ;

  // register byte offsets
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_NUM  = 8'h04;
  localparam logic [7:0] ADDR_DEN  = 8'h08;
  localparam logic [7:0] ADDR_REF  = 8'h0c;
  localparam logic [7:0] ADDR_VCO  = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // field positions
  localparam int CFG0_NINT_LSB = 0;
  localparam int CFG0_ORD_LSB  = 16;
  localparam int CFG0_DITH_LSB = 18;
  localparam int FRAC_LSB      = 0;
  localparam int REF_RDIV_LSB  = 0;
  localparam int REF_DBL_BIT   = 12;
  localparam int REF_ODIV_LSB  = 16;
  localparam int REF_FREQ_LSB  = 24;
  localparam int VCO_CORE_LSB  = 0;
  localparam int VCO_CAP_LSB   = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_NDIV_LSB = 4;

  // reset values and limits
  localparam logic [15:0] RST_NINT      = 16'h0064;
  localparam logic [21:0] RST_NUM       = 22'h000000;
  localparam logic [21:0] DEN_MIN       = 22'h000001;
  localparam logic [11:0] RST_RDIV      = 12'h001;
  localparam logic [5:0]  RST_ODIV      = 6'h01;
  localparam logic [7:0]  RST_FREQ      = 8'h00;
  localparam logic [1:0]  RST_CORE      = 2'h2;
  localparam logic [7:0]  RST_CAP       = 8'h7f;
  localparam logic [1:0]  CORE_FOUR     = 2'h3;
  localparam logic [7:0]  CAP_SHORT_MAX = 8'h0f;
  localparam logic [15:0] LFSR_SEED     = 16'hace1;
  localparam logic [15:0] LFSR_TAPS     = 16'hb400;

  // modulator order and dithering
  typedef enum logic [1:0] {
    ORD_INT = 2'h0, ORD_FIRST = 2'h1, ORD_SECOND = 2'h2, ORD_THIRD = 2'h3
  } fnd_order_t;
  typedef enum logic [1:0] {
    DITH_OFF = 2'h0, DITH_WEAK = 2'h1, DITH_MID = 2'h2, DITH_STRONG = 2'h3
  } fnd_dith_t;

  // calibration sequencer states
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001, CAL_RUN = 3'b010, CAL_DONE = 3'b100
  } fnd_cal_st_t;
endpackage : fnd_pkg

// file: src/fnd_ref_path.sv
`timescale 1ns/1ns
module fnd_ref_path (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // reference path setup
  input  wire logic [11:0] r_div,
  input  wire logic        doubler,
  // phase-detector event
  output logic             pd_tick
);
  typedef struct packed {
    logic [12:0] acc;
    logic        tick;
  } fnd_ref_st_t;

  fnd_ref_st_t s_r;
  fnd_ref_st_t s_nxt;
  logic [13:0] sum;
  logic [13:0] rdiv;

  // doubler adds two half-periods a cycle, divider takes r away
  always_comb begin
    s_nxt = s_r;
    rdiv = (r_div == 12'h000) ? 14'h0001 : {2'h0, r_div};
    sum = {1'b0, s_r.acc} + (doubler ? 14'h0002 : 14'h0001);
    s_nxt.tick = (sum >= rdiv);
    s_nxt.acc = sum[12:0];
    if (sum >= rdiv) begin
      if (!doubler || ((sum - rdiv) >= rdiv)) begin
        s_nxt.acc = 13'h0000;
      end else begin
        s_nxt.acc = 13'(sum - rdiv);
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pd_tick = s_r.tick;
endmodule : fnd_ref_path

// file: src/fnd_dsm.sv
`timescale 1ns/1ns
module fnd_dsm (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // control
  input  wire logic                clear,
  input  wire logic                advance,
  input  wire fnd_pkg::fnd_order_t order,
  input  wire fnd_pkg::fnd_dith_t  dither,
  input  wire logic [21:0]         num,
  input  wire logic [21:0]         den,
  input  wire logic [15:0]         n_int,
  // divide value for this phase-detector cycle
  output logic [15:0]              n_div
);
  typedef struct packed {
    logic [21:0] acc1;
    logic [21:0] acc2;
    logic [21:0] acc3;
    logic        c2_d;
    logic        c3_d;
    logic        c3_dd;
    logic [15:0] lfsr;
    logic [15:0] n_div;
  } fnd_dsm_st_t;

  fnd_dsm_st_t s_r;
  fnd_dsm_st_t s_nxt;
  logic [21:0] dith;
  logic [22:0] inc;
  logic [22:0] r1;
  logic [22:0] r2;
  logic [22:0] r3;
  logic [3:0]  off;
  logic        hi2;
  logic        hi3;

  // add modulo m, carry out in the top bit
  function automatic logic [22:0] fnd_mod_add(input logic [21:0] a,
                                               input logic [21:0] b,
                                               input logic [21:0] m);
    logic [22:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, m}) begin
      fnd_mod_add = {1'b1, 22'(s - {1'b0, m})};
    end else begin
      fnd_mod_add = s;
    end
  endfunction : fnd_mod_add

  // three cascaded accumulators, order picks how many are used
  always_comb begin
    s_nxt = s_r;
    hi2 = (order == fnd_pkg::ORD_SECOND) || (order == fnd_pkg::ORD_THIRD);
    hi3 = (order == fnd_pkg::ORD_THIRD);
    case (dither)
      fnd_pkg::DITH_WEAK:   dith = {21'h000000, s_r.lfsr[0]};
      fnd_pkg::DITH_MID:    dith = {20'h00000, s_r.lfsr[1:0]};
      fnd_pkg::DITH_STRONG: dith = {18'h00000, s_r.lfsr[3:0]};
      default:              dith = 22'h000000;
    endcase
    inc = {1'b0, num} + {1'b0, dith};
    if (inc >= {1'b0, den}) begin
      inc = {1'b0, den} - 23'h000001;
    end
    r1 = fnd_mod_add(s_r.acc1, inc[21:0], den);
    r2 = fnd_mod_add(s_r.acc2, r1[21:0], den);
    r3 = fnd_mod_add(s_r.acc3, r2[21:0], den);
    off = {3'h0, r1[22]};
    if (hi2) begin
      off = off + {3'h0, r2[22]} - {3'h0, s_r.c2_d};
    end
    if (hi3) begin
      off = off + {3'h0, r3[22]} - {2'h0, s_r.c3_d, 1'b0}
          + {3'h0, s_r.c3_dd};
    end
    if (clear) begin
      s_nxt       = '0;
      s_nxt.lfsr  = fnd_pkg::LFSR_SEED;
      s_nxt.n_div = n_int;
    end else if (advance) begin
      s_nxt.lfsr = {1'b0, s_r.lfsr[15:1]}
                 ^ (s_r.lfsr[0] ? fnd_pkg::LFSR_TAPS : 16'h0000);
      if (order == fnd_pkg::ORD_INT) begin
        s_nxt.acc1  = 22'h000000;
        s_nxt.acc2  = 22'h000000;
        s_nxt.acc3  = 22'h000000;
        s_nxt.c2_d  = 1'b0;
        s_nxt.c3_d  = 1'b0;
        s_nxt.c3_dd = 1'b0;
        s_nxt.n_div = n_int;
      end else begin
        s_nxt.acc1  = r1[21:0];
        s_nxt.acc2  = hi2 ? r2[21:0] : 22'h000000;
        s_nxt.acc3  = hi3 ? r3[21:0] : 22'h000000;
        s_nxt.c2_d  = hi2 & r2[22];
        s_nxt.c3_d  = hi3 & r3[22];
        s_nxt.c3_dd = s_r.c3_d;
        s_nxt.n_div = n_int + {{12{off[3]}}, off};
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign n_div = s_r.n_div;
endmodule : fnd_dsm

// file: src/fnd_top.sv
`timescale 1ns/1ns
// Summary of operation
// - fout = ref x doubler / r x (n_int + num/den) / output divide.
// - any fractional denominator from 1 to 4,194,303 is accepted.
// - feedback ratio is integer part plus numerator over denominator.
// - modulator order runs from integer mode up to third order.
// - several dithering modes are selectable by software.
// - writing the first configuration word resets the modulator state.
// - reference may pass doubler, r divider, or both, before phase detector.
// - calibration takes about 115 us, or 5 us from core four with a cap code of 0x0f or below.
module fnd_top #(
  parameter int unsigned CAL_LONG_CYC = fnd_pkg::CAL_LONG_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // synthesizer control
  output logic             pd_tick,
  output logic      [15:0] fb_div,
  output logic      [5:0]  output_divide_value,
  output logic             cal_busy
);
  typedef struct packed {
    logic [15:0]          n_int;
    fnd_pkg::fnd_order_t  order;
    fnd_pkg::fnd_dith_t   dither;
    logic [21:0]          num;
    logic [21:0]          den;
    logic [11:0]          r_div;
    logic                 dbl;
    logic [5:0]           odiv;
    logic [7:0]           freq;
    logic [1:0]           core;
    logic [7:0]           cap;
    fnd_pkg::fnd_cal_st_t cal_st;
    logic [15:0]          cal_cnt;
    logic                 cal_short;
    logic                 cal_done;
    logic                 dsm_clr;
    logic [15:0]          busy_len;
    logic [31:0]          rdata;
  } fnd_top_st_t;

  localparam fnd_top_st_t ST_RST = '{
    n_int:     fnd_pkg::RST_NINT,
    order:     fnd_pkg::ORD_INT,
    dither:    fnd_pkg::DITH_OFF,
    num:       fnd_pkg::RST_NUM,
    den:       fnd_pkg::DEN_MIN,
    r_div:     fnd_pkg::RST_RDIV,
    dbl:       1'b0,
    odiv:      fnd_pkg::RST_ODIV,
    freq:      fnd_pkg::RST_FREQ,
    core:      fnd_pkg::RST_CORE,
    cap:       fnd_pkg::RST_CAP,
    cal_st:    fnd_pkg::CAL_IDLE,
    cal_cnt:   16'h0000,
    cal_short: 1'b0,
    cal_done:  1'b0,
    dsm_clr:   1'b0,
    busy_len:  16'h0000,
    rdata:     32'h0000_0000
  };

  fnd_top_st_t s_r;
  fnd_top_st_t s_nxt;
  logic        addr_ok;
  logic        wr_acc;
  logic        wr_cfg0;
  logic        rd_setup;
  logic        short_sel;
  logic [31:0] rd;

  // mapped word offsets
  function automatic logic fnd_addr_ok(input logic [7:0] a);
    case (a)
      fnd_pkg::ADDR_CFG0, fnd_pkg::ADDR_NUM, fnd_pkg::ADDR_DEN,
      fnd_pkg::ADDR_REF, fnd_pkg::ADDR_VCO,
      fnd_pkg::ADDR_STAT: fnd_addr_ok = 1'b1;
      default:            fnd_addr_ok = 1'b0;
    endcase
  endfunction : fnd_addr_ok

  // bus decode
  assign addr_ok   = fnd_addr_ok(paddr);
  assign wr_acc    = psel & penable & pwrite & addr_ok;
  assign wr_cfg0   = wr_acc & (paddr == fnd_pkg::ADDR_CFG0);
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign short_sel = (s_r.core == fnd_pkg::CORE_FOUR)
                   && (s_r.cap <= fnd_pkg::CAP_SHORT_MAX);

  // sequencer, read capture and register writes
  always_comb begin
    s_nxt         = s_r;
    s_nxt.dsm_clr = 1'b0;
    rd            = 32'h0000_0000;
    // calibration runs on the reference clock itself
    case (s_r.cal_st)
      fnd_pkg::CAL_IDLE: s_nxt.cal_st = fnd_pkg::CAL_IDLE;
      fnd_pkg::CAL_RUN: begin
        if (s_r.cal_cnt == 16'h0000) begin
          s_nxt.cal_st   = fnd_pkg::CAL_DONE;
          s_nxt.cal_done = 1'b1;
        end else begin
          s_nxt.cal_cnt = s_r.cal_cnt - 16'h0001;
        end
      end
      fnd_pkg::CAL_DONE: s_nxt.cal_st = fnd_pkg::CAL_DONE;
      default:           s_nxt.cal_st = fnd_pkg::CAL_IDLE;
    endcase
    // length of the current calibration, for checking only
    if (cal_busy) begin
      s_nxt.busy_len = s_r.busy_len + 16'h0001;
    end
    // read data is taken in the setup phase
    case (paddr)
      fnd_pkg::ADDR_CFG0: begin
        rd[fnd_pkg::CFG0_NINT_LSB +: 16] = s_r.n_int;
        rd[fnd_pkg::CFG0_ORD_LSB +: 2]   = s_r.order;
        rd[fnd_pkg::CFG0_DITH_LSB +: 2]  = s_r.dither;
      end
      fnd_pkg::ADDR_NUM: rd[fnd_pkg::FRAC_LSB +: 22] = s_r.num;
      fnd_pkg::ADDR_DEN: rd[fnd_pkg::FRAC_LSB +: 22] = s_r.den;
      fnd_pkg::ADDR_REF: begin
        rd[fnd_pkg::REF_RDIV_LSB +: 12] = s_r.r_div;
        rd[fnd_pkg::REF_DBL_BIT]        = s_r.dbl;
        rd[fnd_pkg::REF_ODIV_LSB +: 6]  = s_r.odiv;
        rd[fnd_pkg::REF_FREQ_LSB +: 8]  = s_r.freq;
      end
      fnd_pkg::ADDR_VCO: begin
        rd[fnd_pkg::VCO_CORE_LSB +: 2] = s_r.core;
        rd[fnd_pkg::VCO_CAP_LSB +: 8]  = s_r.cap;
      end
      fnd_pkg::ADDR_STAT: begin
        rd[fnd_pkg::STAT_BUSY_BIT]      = cal_busy;
        rd[fnd_pkg::STAT_DONE_BIT]      = s_r.cal_done;
        rd[fnd_pkg::STAT_NDIV_LSB +: 16] = fb_div;
      end
      default: rd = 32'h0000_0000;
    endcase
    if (rd_setup) begin
      s_nxt.rdata = rd;
    end
    // writes land at the access edge
    if (wr_acc) begin
      case (paddr)
        fnd_pkg::ADDR_CFG0: begin
          s_nxt.n_int  = pwdata[fnd_pkg::CFG0_NINT_LSB +: 16];
          s_nxt.order  =
            fnd_pkg::fnd_order_t'(pwdata[fnd_pkg::CFG0_ORD_LSB +: 2]);
          s_nxt.dither =
            fnd_pkg::fnd_dith_t'(pwdata[fnd_pkg::CFG0_DITH_LSB +: 2]);
          s_nxt.dsm_clr   = 1'b1;
          s_nxt.cal_st    = fnd_pkg::CAL_RUN;
          s_nxt.cal_short = short_sel;
          s_nxt.cal_done  = 1'b0;
          s_nxt.busy_len  = 16'h0000;
          s_nxt.cal_cnt   = short_sel
                          ? 16'(fnd_pkg::CAL_SHORT_CYC - 1)
                          : 16'(CAL_LONG_CYC - 1);
        end
        fnd_pkg::ADDR_NUM: begin
          s_nxt.num = pwdata[fnd_pkg::FRAC_LSB +: 22];
        end
        fnd_pkg::ADDR_DEN: begin
          if (pwdata[fnd_pkg::FRAC_LSB +: 22] == 22'h000000) begin
            s_nxt.den = fnd_pkg::DEN_MIN;
          end else begin
            s_nxt.den = pwdata[fnd_pkg::FRAC_LSB +: 22];
          end
        end
        fnd_pkg::ADDR_REF: begin
          s_nxt.r_div = pwdata[fnd_pkg::REF_RDIV_LSB +: 12];
          s_nxt.dbl   = pwdata[fnd_pkg::REF_DBL_BIT];
          s_nxt.odiv  = pwdata[fnd_pkg::REF_ODIV_LSB +: 6];
          s_nxt.freq  = pwdata[fnd_pkg::REF_FREQ_LSB +: 8];
        end
        fnd_pkg::ADDR_VCO: begin
          s_nxt.core = pwdata[fnd_pkg::VCO_CORE_LSB +: 2];
          s_nxt.cap  = pwdata[fnd_pkg::VCO_CAP_LSB +: 8];
        end
        default: s_nxt.dsm_clr = 1'b0;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // reference doubler and r divider to the phase detector
  fnd_ref_path u_ref (
    .pclk    (pclk),
    .presetn (presetn),
    .r_div   (s_r.r_div),
    .doubler (s_r.dbl),
    .pd_tick (pd_tick)
  );

  // feedback divide value with fractional modulation
  fnd_dsm u_dsm (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (s_r.dsm_clr),
    .advance (pd_tick),
    .order   (s_r.order),
    .dither  (s_r.dither),
    .num     (s_r.num),
    .den     (s_r.den),
    .n_int   (s_r.n_int),
    .n_div   (fb_div)
  );

  // bus answers and control outputs
  assign prdata              = s_r.rdata;
  assign pready              = 1'b1;
  assign pslverr             = psel & penable & ~addr_ok;
  assign output_divide_value = s_r.odiv;
  assign cal_busy            = (s_r.cal_st == fnd_pkg::CAL_RUN);

  property p_cal_start;
    @(posedge pclk) disable iff (!presetn)
    wr_cfg0 |=> cal_busy;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not start after first word");

  property p_cal_short;
    @(posedge pclk) disable iff (!presetn)
    ($fell(cal_busy) && s_r.cal_short)
      |-> (s_r.busy_len == 16'(fnd_pkg::CAL_SHORT_CYC));
  endproperty
  a_cal_short: assert property (p_cal_short)
    else $error("short calibration has wrong length");

  property p_cal_long;
    @(posedge pclk) disable iff (!presetn)
    ($fell(cal_busy) && !s_r.cal_short)
      |-> (s_r.busy_len == 16'(CAL_LONG_CYC));
  endproperty
  a_cal_long: assert property (p_cal_long)
    else $error("long calibration has wrong length");

  property p_dsm_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_cfg0 |=> ##1 (fb_div == $past(pwdata[15:0], 2));
  endproperty
  a_dsm_clear: assert property (p_dsm_clear)
    else $error("modulator not cleared by first word");

  property p_int_mode;
    @(posedge pclk) disable iff (!presetn)
    (pd_tick && (s_r.order == fnd_pkg::ORD_INT) && !wr_acc)
      |=> (fb_div == s_r.n_int);
  endproperty
  a_int_mode: assert property (p_int_mode)
    else $error("integer mode divide value differs from integer part");

  property p_den_min;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && (paddr == fnd_pkg::ADDR_DEN) && (pwdata[21:0] == 22'h0))
      |=> (s_r.den == 22'h000001);
  endproperty
  a_den_min: assert property (p_den_min)
    else $error("zero denominator not raised to one");

  property p_pd_gap;
    @(posedge pclk) disable iff (!presetn)
    (pd_tick && !s_r.dbl && (s_r.r_div >= 12'h002)) |=> !pd_tick;
  endproperty
  a_pd_gap: assert property (p_pd_gap)
    else $error("phase detector ticks too fast for r divider");

  property p_pd_dbl;
    @(posedge pclk) disable iff (!presetn)
    (s_r.dbl && (s_r.r_div == 12'h001)) |=> pd_tick;
  endproperty
  a_pd_dbl: assert property (p_pd_dbl)
    else $error("doubled reference missed a tick");

  property p_cov_short;
    @(posedge pclk) disable iff (!presetn)
    $fell(cal_busy) && s_r.cal_short;
  endproperty
  c_cov_short: cover property (p_cov_short);

  property p_cov_long;
    @(posedge pclk) disable iff (!presetn)
    $fell(cal_busy) && !s_r.cal_short;
  endproperty
  c_cov_long: cover property (p_cov_long);

  property p_cov_third;
    @(posedge pclk) disable iff (!presetn)
    pd_tick && (s_r.order == fnd_pkg::ORD_THIRD)
      && (s_r.dither == fnd_pkg::DITH_STRONG);
  endproperty
  c_cov_third: cover property (p_cov_third);
endmodule : fnd_top

// file: verification/fnd_host_model.sv
`timescale 1ns/1ns
module fnd_host_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // one transfer, held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d; // released data does not linger
  endtask : xfer

  // plain write, response ignored
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, a, d, rd, err);
  endtask : wr

  // reference and core set up before the first word lands
  task automatic cfg_start(input logic [31:0] refw, input logic [31:0] vco,
                           input logic [31:0] cfg0);
    wr(fnd_pkg::ADDR_REF, refw);
    wr(fnd_pkg::ADDR_VCO, vco);
    wr(fnd_pkg::ADDR_CFG0, cfg0);
  endtask : cfg_start
endmodule : fnd_host_model

// file: verification/fractional_n_divider_control_tb_top.sv
`timescale 1ns/1ns
module fractional_n_divider_control_tb_top;
  localparam int unsigned CAL_LONG = 40;
  localparam logic [31:0] REF1 = 32'h0001_0001;
  // register rows: write flag, address, write data, read expectation
  localparam logic [72:0] RROWS [10] = '{
    {1'b0, 8'h00, 32'h0, 32'h0000_0064}, {1'b0, 8'h04, 32'h0, 32'h0},
    {1'b0, 8'h08, 32'h0, 32'h0000_0001}, {1'b0, 8'h0c, 32'h0, REF1},
    {1'b0, 8'h10, 32'h0, 32'h0000_7f02}, {1'b0, 8'h14, 32'h0, 32'h640},
    {1'b1, 8'h04, 32'hffff_ffff, 32'h003f_ffff},
    {1'b1, 8'h08, 32'h0, 32'h0000_0001},
    {1'b1, 8'h08, 32'h003f_ffff, 32'h003f_ffff},
    {1'b1, 8'h14, 32'hffff_ffff, 32'h640}};
  // modulator rows: order, dither, offset low, offset high
  localparam int MROWS [8][4] = '{'{0, 0, 0, 0}, '{1, 0, 0, 1},
    '{2, 0, -1, 2}, '{3, 0, -3, 4}, '{3, 1, -3, 4}, '{3, 2, -3, 4},
    '{3, 3, -3, 4}, '{2, 3, -1, 2}};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pd_tick;
  logic [15:0] fb_div;
  logic [5:0]  output_divide_value;
  logic        cal_busy;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          n_compared;
  int          sum;
  int          mn;
  int          mx;
  int          cnt;
  int          seq1 [$];
  int          seq [$];

  // device under test
  fnd_top #(.CAL_LONG_CYC(CAL_LONG)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pd_tick(pd_tick),
    .fb_div(fb_div), .output_divide_value(output_divide_value),
    .cal_busy(cal_busy));

  // host on the register bus
  fnd_host_model host_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // reference clock, 100 MHz
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // verdict
  task automatic end_of_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // offsets of fb_div from n_int 0x0100 over n ticks
  task automatic collect(input int n);
    int k;
    int v;
    k   = 0;
    sum = 0;
    mn  = 99;
    mx  = -99;
    seq.delete();
    for (int c = 0; c < 20 * n && k < n; c++) begin
      @(posedge pclk);
      #1;
      if (pd_tick === 1'b1) begin
        v = int'(fb_div) - 256;
        sum += v;
        mn = (v < mn) ? v : mn;
        mx = (v > mx) ? v : mx;
        seq.push_back(v);
        k++;
      end
    end
  endtask : collect

  // edges with calibration running after a first-word write
  task automatic cal_len(input logic [31:0] vco);
    host_u.cfg_start(REF1, vco, 32'h0000_0100);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (cal_busy === 1'b1 && cnt < 2000);
    cnt--;
  endtask : cal_len

  // watchdog
  initial begin
    #500_000;
    num_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    num_errors = 0;
    n_compared = 0;
    presetn    = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    foreach (RROWS[i]) begin
      if (RROWS[i][72]) host_u.wr(RROWS[i][71:64], RROWS[i][63:32]);
      host_u.xfer(1'b0, RROWS[i][71:64], 32'h0, rd, err);
      check("reg_read", rd, RROWS[i][31:0]);
    end
    foreach (MROWS[i]) begin
      host_u.wr(fnd_pkg::ADDR_NUM, 32'd400);
      host_u.wr(fnd_pkg::ADDR_DEN, 32'd1000);
      host_u.cfg_start(REF1, 32'h7f02, {12'h0, 2'(MROWS[i][1]),
                       2'(MROWS[i][0]), 16'h0100});
      collect(100);
      check("offset_lo", 32'(mn >= MROWS[i][2]), 32'h1);
      check("offset_hi", 32'(mx <= MROWS[i][3]), 32'h1);
      if (MROWS[i][0] == 0) check("int_sum", 32'(sum), 32'h0);
      else check("mean", 32'(sum >= 34 && sum <= 46), 32'h1);
    end
    // first order over one full period of den=5, num=2
    host_u.wr(fnd_pkg::ADDR_NUM, 32'd2);
    host_u.wr(fnd_pkg::ADDR_DEN, 32'd5);
    host_u.cfg_start(REF1, 32'h7f02, 32'h0001_0100);
    collect(7);
    collect(5);
    check("period_sum", 32'(sum), 32'd2);
    // same pattern after every first-word write
    host_u.cfg_start(REF1, 32'h7f02, 32'h0003_0100);
    collect(20);
    seq1 = seq;
    host_u.cfg_start(REF1, 32'h7f02, 32'h0003_0100);
    collect(20);
    foreach (seq1[i]) check("repeat", 32'(seq[i]), 32'(seq1[i]));
    // reference path spacing and output divider
    host_u.wr(fnd_pkg::ADDR_REF, 32'h0005_0004);
    @(posedge pclk);
    check("odiv", 32'(output_divide_value), 32'h5);
    do @(posedge pclk); while (pd_tick !== 1'b1);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (pd_tick !== 1'b1 && cnt < 50);
    check("rdiv_gap", 32'(cnt), 32'd4);
    for (int j = 0; j < 2; j++) begin
      host_u.wr(fnd_pkg::ADDR_REF, j ? 32'h0001_1001 : 32'h0001_1004);
      repeat (4) @(posedge pclk); // let the new tick rate settle
      cnt = 0;
      repeat (40) begin
        @(posedge pclk);
        cnt += (pd_tick === 1'b1);
      end
      check("dbl_ticks", 32'(cnt), j ? 32'd40 : 32'd20);
    end
    // unmapped address refused
    host_u.xfer(1'b1, 8'h18, 32'h1234_5678, rd, err);
    check("unmapped_werr", 32'(err), 32'h1);
    host_u.xfer(1'b0, 8'h18, 32'h0, rd, err);
    check("unmapped_rd", rd, 32'h0);
    check("unmapped_rerr", 32'(err), 32'h1);
    // calibration length by starting core and code
    cal_len(32'h0f03);
    check("cal_short", 32'(cnt), 32'(fnd_pkg::CAL_SHORT_CYC));
    cal_len(32'h1003);
    check("cal_long_cap", 32'(cnt), 32'(CAL_LONG));
    cal_len(32'h0f02);
    check("cal_long_core", 32'(cnt), 32'(CAL_LONG));
    host_u.xfer(1'b0, fnd_pkg::ADDR_STAT, 32'h0, rd, err);
    check("cal_done", {30'h0, rd[1:0]}, 32'h2);
    // reset in mid-run while a calibration is running
    host_u.cfg_start(32'h0005_0001, 32'h7f02, 32'h0001_0123);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    #1;
    check("rst_busy", 32'(cal_busy), 32'h0);
    check("rst_fb_div", 32'(fb_div), 32'h0);
    check("rst_tick", 32'(pd_tick), 32'h0);
    check("rst_odiv", 32'(output_divide_value), 32'h1);
    check("rst_prdata", prdata, 32'h0);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    host_u.xfer(1'b0, fnd_pkg::ADDR_CFG0, 32'h0, rd, err);
    check("rst_cfg0", rd, 32'h0000_0064);
    host_u.xfer(1'b0, fnd_pkg::ADDR_STAT, 32'h0, rd, err);
    check("rst_stat", {30'h0, rd[1:0]}, 32'h0);
    end_of_test();
  end
endmodule : fractional_n_divider_control_tb_top
